// ### ascp_buf2.v
// Purpose: two-entry valid/ready buffer for converter results
// Assumes: single clock, async active-high reset
// Notes:   input ready is a full flag inverse decoded from the registered fill count
`timescale 1ns/1ps
module ascp_buf2
(
   input  wire        clk_i,     // system clock
   input  wire        rst_i,     // async reset
   input  wire        in_valid_i,// word offered
   output wire        in_ready_o,// room for a word
   input  wire [11:0] in_data_i, // word in
   output wire        out_valid_o,// word available
   input  wire        out_ready_i,// consumer takes word
   output wire [11:0] out_data_o // oldest word
);
   reg [11:0] mem_q [0:1];
   reg        wp_q;
   reg        rp_q;
   reg [1:0]  cnt_q;
   wire       push = in_valid_i & in_ready_o;
   wire       pop  = out_valid_o & out_ready_i;
   assign in_ready_o  = (cnt_q != 2'd2);
   assign out_valid_o = (cnt_q != 2'd0);
   assign out_data_o  = mem_q[rp_q];
   // pointers and fill count
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q <= 2'd0;
      end
      else
      begin
         if (push)
            wp_q <= ~wp_q;
         if (pop)
            rp_q <= ~rp_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end
   // storage, no reset needed
   always @(posedge clk_i)
   begin
      if (push)
         mem_q[wp_q] <= in_data_i;
   end
endmodule

// ### ascp_host.sv
// Purpose: host serial port, one frame per go
// Assumes: 160 ns shift clock, low between frames
// Notes:   result sampled on shift-clock rises
`timescale 1ns/1ps
module ascp_host
(
   input  wire        clk_i,          // clock
   input  wire        go_i,           // start frame
   input  wire [7:0]  tx_i,           // byte out
   input  wire        sdo_i,          // result pin
   output reg         sel_n_o = 1'b1, // select
   output reg         sclk_o = 1'b0,  // shift clock
   output reg         sdi_o = 1'b0,   // data pin
   output reg         busy_o = 1'b0,  // in frame
   output reg  [11:0] rx_o = 12'h000  // result in
);
   integer i;
   // =======================================
   // frame: select, 12 clocks, release
   always @(posedge clk_i)
   begin
      if (go_i && !busy_o)
      begin
         busy_o <= 1'b1;
         sel_n_o <= 1'b0;
         repeat (8) @(posedge clk_i);
         for (i = 0; i < 12; i = i + 1)
         begin
            sdi_o <= (i < 8) ? tx_i[7 - i] : ~sdi_o;
            repeat (16) @(posedge clk_i);
            sclk_o <= 1'b1;
            rx_o <= {rx_o[10:0], sdo_i};
            repeat (16) @(posedge clk_i);
            sclk_o <= 1'b0;
         end
         repeat (8) @(posedge clk_i);
         sel_n_o <= 1'b1;
         sdi_o <= ~sdi_o; // no stale level once released
         busy_o <= 1'b0;
      end
   end
endmodule

// ### ascp_port.v
// Purpose: serial control and result port of a 12-bit converter
// Assumes: select, shift clock and serial input come from another domain
// Notes:   conversion engine outside; result arrives via valid/ready
// Summary of operation
// - select falling clears counters and control, enables input, clock and output
// - select rising stops response to serial input and shift clock
// - 4-bit channel address, msb first, on first four rising edges
// - after the address, remaining input bits keep shifting in order
// - serial output high impedance while select high, driven while low
// - first result bit, msb or lsb by order, shown when select valid
// - each later falling edge presents the next result bit
// - end-of-conversion low after last falling edge until result ready
// - eight input bits loaded on first eight rising edges
// - channel address to multiplexer right after fourth rising edge
// - sampling from fourth falling edge to last falling edge
// - remaining 11 result bits shift out on falling edges
// - last falling edge hands conversion to internal controller
`timescale 1ns/1ps
`include "ascp_regs.vh"
module ascp_port
(
   input  wire        clk_i,        // 200 MHz system clock
   input  wire        rst_i,        // async reset, active high
   input  wire        sel_n_i,      // select pin, active low
   input  wire        sclk_i,       // shift clock pin
   input  wire        sdi_i,        // serial input pin
   input  wire        lsb_first_i,  // result bit order, 1 = lsb first
   output reg         sdo_o,        // serial output data
   output reg         sdo_oe_o,     // serial output enable
   output reg         eoc_o,        // end of conversion
   output reg  [3:0]  chan_addr_o,  // channel to input multiplexer
   output reg         chan_vld_o,   // address captured this transfer
   output reg  [7:0]  in_data_o,    // input data register
   output reg         sampling_o,   // sampling window active
   output reg         conv_start_o, // pulse: controller takes over
   output reg  [3:0]  conv_chan_o,  // channel for the conversion
   input  wire        res_valid_i,  // conversion result offered
   output wire        res_ready_o,  // buffer has room
   input  wire [11:0] res_data_i    // conversion result
);
   // ==========================================================
   // pin synchronisers
   // ==========================================================
   reg [1:0] sel_s_q;
   reg [1:0] clk_s_q;
   reg [1:0] dat_s_q;
   reg       sel_d_q;
   reg       clk_d_q;
   // two flops each; edge detect only on the second stage
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sel_s_q <= 2'b11;
         clk_s_q <= 2'b00;
         dat_s_q <= 2'b00;
         sel_d_q <= 1'b1;
         clk_d_q <= 1'b0;
      end
      else
      begin
         sel_s_q <= {sel_s_q[0], sel_n_i};
         clk_s_q <= {clk_s_q[0], sclk_i};
         dat_s_q <= {dat_s_q[0], sdi_i};
         sel_d_q <= sel_s_q[1];
         clk_d_q <= clk_s_q[1];
      end
   end
   // ==========================================================
   // edge detection
   // ==========================================================
   // two shared functions keep every pin edge detector alike
   function edge_up;
      input now_v;   // second synchroniser stage
      input was_v;   // value one cycle earlier
      begin
         edge_up = now_v & ~was_v;
      end
   endfunction

   function edge_down;
      input now_v;   // second synchroniser stage
      input was_v;   // value one cycle earlier
      begin
         edge_down = ~now_v & was_v;
      end
   endfunction

   // select is active low; both edges come from the synced copy only
   wire sel_low  = ~sel_s_q[1];
   wire sel_fall = edge_down(sel_s_q[1], sel_d_q);
   wire sel_rise = edge_up(sel_s_q[1], sel_d_q);
   // shift clock is ignored unless select is and was low
   wire active   = sel_low & ~sel_d_q;
   wire clk_rise = active & edge_up(clk_s_q[1], clk_d_q);
   wire clk_fall = active & edge_down(clk_s_q[1], clk_d_q);

   // ==========================================================
   // result buffer
   // ==========================================================
   wire        buf_vld;
   wire [11:0] buf_data;
   reg         buf_pop;
   ascp_buf2 u_buf
   (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (res_valid_i),
      .in_ready_o  (res_ready_o),
      .in_data_i   (res_data_i),
      .out_valid_o (buf_vld),
      .out_ready_i (buf_pop),
      .out_data_o  (buf_data)
   );

   // ==========================================================
   // transfer state
   // ==========================================================
   reg [`ASCP_CNT_W-1:0] rise_cnt_q;
   reg [`ASCP_CNT_W-1:0] fall_cnt_q;
   reg [11:0]            res_q;     // latched previous result
   reg [11:0]            shf_q;     // output shifter

   function [11:0] bitrev12;
      input [11:0] v;
      integer k;
      begin
         for (k = 0; k < 12; k = k + 1)
            bitrev12[k] = v[11-k];
      end
   endfunction

   // first bit chosen by order setting; shifter always sends msb
   wire [11:0] res_ord = lsb_first_i ? bitrev12(res_q) : res_q;
   wire        last_fall = clk_fall & (fall_cnt_q == `ASCP_RES_BITS - 5'd1);

   // ==========================================================
   // link phase
   // ==========================================================
   localparam [1:0] LK_IDLE = 2'b00;  // deselected, pins ignored
   localparam [1:0] LK_ADDR = 2'b01;  // first four rising edges
   localparam [1:0] LK_DATA = 2'b10;  // rest of the frame
   localparam [1:0] LK_DONE = 2'b11;  // handed over, waiting for select rise
   reg [1:0] lk_q;
   reg [1:0] lk_d;
   // address capture is tied to the phase so a stray count cannot reload it
   wire addr_edge = clk_rise & (lk_q == LK_ADDR) & (rise_cnt_q == `ASCP_ADDR_LAST);

   // next phase
   always @*
   begin
      lk_d = lk_q;
      case (lk_q)
         LK_IDLE:
         begin
            if (sel_fall)
               lk_d = LK_ADDR;
         end
         LK_ADDR:
         begin
            if (addr_edge)
               lk_d = LK_DATA;
         end
         LK_DATA:
         begin
            if (last_fall)
               lk_d = LK_DONE;
         end
         LK_DONE:
         begin
            lk_d = LK_DONE;
         end
         default:
         begin
            lk_d = LK_IDLE;
         end
      endcase
      // a fresh select fall restarts, a rise ends the frame in any phase
      if (sel_fall)
         lk_d = LK_ADDR;
      else if (sel_rise)
         lk_d = LK_IDLE;
   end

   // phase register
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         lk_q <= LK_IDLE;
      else
         lk_q <= lk_d;
   end

   // counters, capture and output shift
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rise_cnt_q   <= {`ASCP_CNT_W{1'b0}};
         fall_cnt_q   <= {`ASCP_CNT_W{1'b0}};
         in_data_o    <= 8'h00;
         chan_addr_o  <= 4'h0;
         chan_vld_o   <= 1'b0;
         sampling_o   <= 1'b0;
         shf_q        <= 12'h000;
         sdo_o        <= 1'b0;
         sdo_oe_o     <= 1'b0;
         conv_start_o <= 1'b0;
         conv_chan_o  <= 4'h0;
      end
      else
      begin
         conv_start_o <= 1'b0;
         // output driven only while select low
         sdo_oe_o <= sel_low;
         if (sel_fall)
         begin
            rise_cnt_q <= {`ASCP_CNT_W{1'b0}};
            fall_cnt_q <= {`ASCP_CNT_W{1'b0}};
            chan_vld_o <= 1'b0;
            sampling_o <= 1'b0;
            shf_q      <= {res_ord[10:0], 1'b0};
            sdo_o      <= res_ord[11];
         end
         else
         begin
            if (clk_rise)
            begin
               if (rise_cnt_q < {1'b0, `ASCP_IN_BITS})
               begin
                  in_data_o  <= {in_data_o[6:0], dat_s_q[1]};
                  rise_cnt_q <= rise_cnt_q + 5'd1;
               end
               // msb-first address complete on fourth rising edge
               if (addr_edge)
               begin
                  chan_addr_o <= {in_data_o[2:0], dat_s_q[1]};
                  chan_vld_o  <= 1'b1;
               end
            end
            if (clk_fall && fall_cnt_q < `ASCP_RES_BITS)
            begin
               fall_cnt_q <= fall_cnt_q + 5'd1;
               if (fall_cnt_q < `ASCP_RES_BITS - 5'd1)
               begin
                  sdo_o <= shf_q[11];
                  shf_q <= {shf_q[10:0], 1'b0};
               end
               if (fall_cnt_q == `ASCP_SAMP_FALL)
                  sampling_o <= 1'b1;
            end
            if (last_fall)
            begin
               sampling_o   <= 1'b0;
               conv_start_o <= 1'b1;
               conv_chan_o  <= chan_addr_o;
            end
         end
      end
   end

   // ==========================================================
   // end of conversion and result latch
   // ==========================================================
   localparam [0:0] CV_READY = 1'b0;  // result held, eoc high
   localparam [0:0] CV_WAIT  = 1'b1;  // conversion handed over, eoc low
   reg cv_q;                          // conversion phase
   // the engine owns timing; no timeout, a result that never comes leaves eoc low
   // a word already waiting is taken at once, so eoc drops for at least one cycle
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cv_q  <= CV_READY;
         eoc_o <= 1'b1;
         res_q <= 12'h000;
      end
      else
      begin
         case (cv_q)
            CV_READY:
            begin
               if (last_fall)
               begin
                  cv_q  <= CV_WAIT;
                  eoc_o <= 1'b0;
               end
            end
            CV_WAIT:
            begin
               if (last_fall)
                  eoc_o <= 1'b0;
               else if (buf_vld)
               begin
                  res_q <= buf_data;
                  cv_q  <= CV_READY;
                  eoc_o <= 1'b1;
               end
            end
            default:
            begin
               cv_q  <= CV_READY;
               eoc_o <= 1'b1;
            end
         endcase
      end
   end
   // pop only while waiting, never in the cycle a new conversion starts
   always @*
   begin
      buf_pop = (cv_q == CV_WAIT) & ~last_fall;
   end
endmodule

// ### ascp_properties.sv
// Purpose: timing checks on the serial port
// Assumes: pins pass a two-flop sync
// Notes:   bound to ascp_port
`timescale 1ns/1ps
module ascp_chk
(
   input wire       clk_i,        // clock
   input wire       rst_i,        // reset
   input wire       sel_n_i,      // select
   input wire       sdo_oe_o,     // out enable
   input wire       eoc_o,        // end of conv
   input wire [3:0] chan_addr_o,  // address
   input wire       chan_vld_o,   // addr valid
   input wire [7:0] in_data_o,    // input reg
   input wire       sampling_o,   // sampling
   input wire       conv_start_o, // handover
   input wire [3:0] conv_chan_o,  // conv chan
   input wire       res_valid_i,  // push
   input wire       res_ready_o   // room
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // =======================================
   // select and output pin
   property p_oe_off; sel_n_i [*5] |-> !sdo_oe_o; endproperty
   a_oe_off: assert property (p_oe_off) else $error("output driven while idle");
   property p_oe_on; $fell(sel_n_i) |-> ##[1:6] sdo_oe_o; endproperty
   a_oe_on: assert property (p_oe_on) else $error("output not enabled");
   // margin of five covers the sync delay after select rises
   property p_quiet; sel_n_i [*5] |-> $stable(in_data_o) && $stable(chan_addr_o); endproperty
   a_quiet: assert property (p_quiet) else $error("shift while deselected");
   // =======================================
   // conversion handover
   property p_eoc_low; conv_start_o |-> !eoc_o; endproperty
   a_eoc_low: assert property (p_eoc_low) else $error("ready flag stayed high");
   property p_pulse; conv_start_o |=> !conv_start_o; endproperty
   a_pulse: assert property (p_pulse) else $error("start not a pulse");
   property p_chan; conv_start_o |-> chan_vld_o && conv_chan_o == chan_addr_o; endproperty
   a_chan: assert property (p_chan) else $error("wrong conversion channel");
   property p_samp; $rose(sampling_o) |-> chan_vld_o; endproperty
   a_samp: assert property (p_samp) else $error("sampling before address");
   property p_samp_end; conv_start_o |-> ##[0:1] !sampling_o; endproperty
   a_samp_end: assert property (p_samp_end) else $error("sampling past last edge");
   property p_eoc_up; !eoc_o && res_valid_i && res_ready_o |-> ##[1:4] eoc_o; endproperty
   a_eoc_up: assert property (p_eoc_up) else $error("ready flag not raised");
   c_start: cover property (conv_start_o);
   c_full: cover property (!res_ready_o);
   c_eoc: cover property ($rose(eoc_o));
endmodule
bind ascp_port ascp_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .sel_n_i(sel_n_i), .sdo_oe_o(sdo_oe_o),
   .eoc_o(eoc_o), .chan_addr_o(chan_addr_o), .chan_vld_o(chan_vld_o), .in_data_o(in_data_o),
   .sampling_o(sampling_o), .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
   .res_valid_i(res_valid_i), .res_ready_o(res_ready_o));

// ### ascp_regs.vh
// Purpose: constants for the converter serial control port
// Assumes: 200 MHz system clock
// Notes:   counts are in shift-clock edges of one transfer
`ifndef ASCP_REGS_VH
`define ASCP_REGS_VH
`define ASCP_ADDR_BITS     3'd4
`define ASCP_IN_BITS       4'd8
`define ASCP_RES_BITS      5'd12
`define ASCP_CNT_W         5
`define ASCP_ADDR_LAST     5'd3
`define ASCP_SAMP_FALL     5'd3
`define ASCP_CONV_TIME_NS  10000
`define ASCP_CLK_NS        5
`define ASCP_CONV_CYC      (`ASCP_CONV_TIME_NS / `ASCP_CLK_NS)
`endif

// ### testbench.sv
// Purpose: self-checking bench for ascp_port
// Assumes: host model makes the link
// Notes:   rows = {check, lsb, result, byte}
`timescale 1ns/1ps
module testbench;
   reg clk_i = 1'b0, rst_i = 1'b1, go_q = 1'b0, lsb_q = 1'b0, vld_q = 1'b0;
   reg [7:0] tx_q = 8'h00;
   reg [11:0] dat_q = 12'h000;
   reg [21:0] rows [0:2];
   wire sel_n, sclk, sdi, sdo, oe, eoc, cv, samp, cst, rdy, busy;
   wire [3:0] ca, cc;
   wire [7:0] idat;
   wire [11:0] rx;
   // an undriven output shows the inverse of its last level
   wire sdo_pin = oe ? sdo : ~sdo;
   integer miscompares = 0, n_compared = 0, k;
   ascp_port dut (.clk_i(clk_i), .rst_i(rst_i), .sel_n_i(sel_n), .sclk_i(sclk), .sdi_i(sdi),
      .lsb_first_i(lsb_q), .sdo_o(sdo), .sdo_oe_o(oe), .eoc_o(eoc), .chan_addr_o(ca), .chan_vld_o(cv),
      .in_data_o(idat), .sampling_o(samp), .conv_start_o(cst), .conv_chan_o(cc),
      .res_valid_i(vld_q), .res_ready_o(rdy), .res_data_i(dat_q));
   ascp_host u_host (.clk_i(clk_i), .go_i(go_q), .tx_i(tx_q), .sdo_i(sdo_pin), .sel_n_o(sel_n),
      .sclk_o(sclk), .sdi_o(sdi), .busy_o(busy), .rx_o(rx));
   initial forever #2.5 clk_i = ~clk_i;
   task chk(input [47:0] nm, input [11:0] got, input [11:0] exp);
   begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
         miscompares = miscompares + 1;
         $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
      end
   end
   endtask
   // one frame, bounded wait on the host
   task xfer(input [7:0] tx, input lsb);
      integer w;
   begin
      @(posedge clk_i);
      tx_q <= tx;
      lsb_q <= lsb;
      go_q <= 1'b1;
      @(posedge clk_i);
      go_q <= 1'b0;
      @(posedge clk_i);
      for (w = 0; busy && w < 1000; w = w + 1) @(posedge clk_i);
      if (w >= 1000) miscompares = miscompares + 1;
      repeat (6) @(posedge clk_i);
      #1;
   end
   endtask
   task print_verdict;
   begin
      if (miscompares == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   // =======================================
   // main sequence
   initial
   begin
      rows[0] = {1'b0, 1'b0, 12'h000, 8'h53};
      rows[1] = {1'b1, 1'b0, 12'hA5C, 8'hBC};
      rows[2] = {1'b1, 1'b1, 12'h87C, 8'h0F};
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk("eoc", {11'h000, eoc}, 12'h001);
      chk("oe", {11'h000, oe}, 12'h000);
      // two words back to back fill the buffer
      @(posedge clk_i);
      vld_q <= 1'b1;
      dat_q <= 12'hA5C;
      @(posedge clk_i);
      dat_q <= 12'h3E1;
      @(posedge clk_i);
      vld_q <= 1'b0;
      #1;
      chk("ready", {11'h000, rdy}, 12'h000);
      for (k = 0; k < 3; k = k + 1)
      begin
         xfer(rows[k][7:0], rows[k][20]);
         chk("addr", {8'h00, ca}, {8'h00, rows[k][7:4]});
         chk("indata", {4'h0, idat}, {4'h0, rows[k][7:0]});
         if (rows[k][21]) chk("result", rx, rows[k][19:8]);
         chk("oe", {11'h000, oe}, 12'h000);
         chk("cchan", {8'h00, cc}, {8'h00, rows[k][7:4]});
         chk("samp", {11'h000, samp}, 12'h000);
      end
      chk("eoc", {11'h000, eoc}, 12'h000);
      @(posedge clk_i);
      vld_q <= 1'b1;
      dat_q <= 12'h6D2;
      @(posedge clk_i);
      vld_q <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
      chk("eoc", {11'h000, eoc}, 12'h001);
      xfer(8'hE7, 1'b0);
      chk("result", rx, 12'h6D2);
      chk("vld", {11'h000, cv}, 12'h001);
      // reset in mid-run: idle outputs, then a frame shows the cleared result
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      chk("eoc", {11'h000, eoc}, 12'h001);
      chk("ready", {11'h000, rdy}, 12'h001);
      chk("vld", {11'h000, cv}, 12'h000);
      @(posedge clk_i);
      rst_i <= 1'b0;
      xfer(8'h9A, 1'b0);
      chk("addr", {8'h00, ca}, 12'h009);
      chk("result", rx, 12'h000);
      print_verdict;
   end
   initial
   begin
      #50000;
      miscompares = miscompares + 1;
      print_verdict;
   end
endmodule
